//--- lsp_parallel_ports.sv
// Chosen here: the AHB-Lite interface to the registers.
`default_nettype none
// What this block does
// - output data is held in latches; pin reads come straight from pads
// - pin levels are sampled in the first cycle of a read
// - driven output changes in the cycle after the data phase of a write
// - octal bit goes to the segment driver when its select bit is one
// - octal output latch resets to all ones
// - latch address reads latch; pin-level register reads the pads
// - pin read of a segment bit is undefined
// - tri port output latch resets to all ones
// - dual-clock mode hands tri pins one and two to the oscillator
// - first tri pin raises the interrupt latch on every falling edge
// - tri pin read returns undefined upper bits seven to three
// - stop mode floats the stop-release pin regardless of output enable
// - quad output type zero is open drain, one is push-pull
// - quad latch resets to ones, output type to zeros
// - quad pin read returns undefined upper bits seven to four
module lsp_parallel_ports (
   input wire logic clk,
   input wire logic rstn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [7:0] octPinIn,
   output logic [7:0] octPinOut,
   output logic [7:0] octPinOe,
   input wire logic [7:0] segmentDrive,
   output logic [7:0] segmentEnable,
   input wire logic [2:0] triPinIn,
   output logic [2:0] triPinOut,
   output logic [2:0] triPinOe,
   output logic [1:0] slowOscEnable,
   output logic extIntEdge,
   input wire logic [3:0] quadPinIn,
   output logic [3:0] quadPinOut,
   output logic [3:0] quadPinOe,
   input wire logic [3:0] quadAltOut,
   input wire logic [3:0] quadAltSel
);
   import lsp_pkg::*;

   logic [7:0] octalPortOutputLatch, next_octalPortOutputLatch;
   logic [7:0] octalPortSegmentSelect, next_octalPortSegmentSelect;
   logic [2:0] triPortOutputLatch, next_triPortOutputLatch;
   logic [3:0] quadPortOutputLatch, next_quadPortOutputLatch;
   logic [3:0] quadPortOutputType, next_quadPortOutputType;
   logic [2:0] modeReg, next_modeReg;
   lsp_acc_t acc, next_acc;
   logic [9:0] accAddr, next_accAddr;
   logic [31:0] rdata, next_rdata;
   logic triPin0Last, next_triPin0Last;
   logic edgeFlag, next_edgeFlag;
   logic addrTaken;
   logic [7:0] octDrive;
   logic [3:0] quadData;
   logic [2:0] triAllow;

   // register picked by a word address; the holes fall to the none code
   typedef enum logic [3:0] {
      REG_NONE,
      REG_OCT_LATCH,
      REG_OCT_SEG,
      REG_OCT_PINS,
      REG_TRI_LATCH,
      REG_TRI_PINS,
      REG_QUAD_LATCH,
      REG_QUAD_TYPE,
      REG_QUAD_PINS,
      REG_MODE
   } lsp_reg_t;

   // one decoder shared by the read mux and the write path, so the two
   // can never disagree about which word sits where
   function automatic lsp_reg_t decodeReg(input logic [9:0] a);
      lsp_reg_t r;
      r = REG_NONE;
      unique case (a)
         ADDR_OCT_LATCH: r = REG_OCT_LATCH;
         ADDR_OCT_SEG: r = REG_OCT_SEG;
         ADDR_OCT_PINS: r = REG_OCT_PINS;
         ADDR_TRI_LATCH: r = REG_TRI_LATCH;
         ADDR_TRI_PINS: r = REG_TRI_PINS;
         ADDR_QUAD_LATCH: r = REG_QUAD_LATCH;
         ADDR_QUAD_TYPE: r = REG_QUAD_TYPE;
         ADDR_QUAD_PINS: r = REG_QUAD_PINS;
         ADDR_MODE: r = REG_MODE;
         default: r = REG_NONE;
      endcase
      return r;
   endfunction

   // pin-level view: pads sampled as-is, upper bits read back as zero;
   // stored words come from the next values, so a read right behind a
   // write to the same word already sees the new data
   function automatic logic [31:0] readMux(input logic [9:0] a);
      logic [31:0] v;
      v = 32'h0000_0000;
      unique case (decodeReg(a))
         REG_OCT_LATCH: v[7:0] = next_octalPortOutputLatch;
         REG_OCT_SEG: v[7:0] = next_octalPortSegmentSelect;
         REG_OCT_PINS: v[7:0] = octPinIn;
         REG_TRI_LATCH: v[2:0] = next_triPortOutputLatch;
         REG_TRI_PINS: v[2:0] = triPinIn;
         REG_QUAD_LATCH: v[3:0] = next_quadPortOutputLatch;
         REG_QUAD_TYPE: v[3:0] = next_quadPortOutputType;
         REG_QUAD_PINS: v[3:0] = quadPinIn;
         REG_MODE: v[2:0] = next_modeReg;
         default: v = 32'h0000_0000; // unmapped words read zero
      endcase
      return v;
   endfunction

   assign addrTaken = hsel & hready & (htrans == HTRANS_NONSEQ);

   // bus sequencing: address phase, then a one-cycle data phase
   always_comb begin
      next_acc = ACC_IDLE;
      next_accAddr = accAddr;
      next_rdata = rdata;
      if (addrTaken) begin
         next_accAddr = {haddr[9:2], 2'b00};
         next_acc = hwrite ? ACC_WRITE : ACC_READ;
         // pads caught in the very first cycle of the read
         if (!hwrite) begin
            next_rdata = readMux({haddr[9:2], 2'b00});
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         acc <= ACC_IDLE;
         accAddr <= 10'h000;
         rdata <= 32'h0000_0000;
      end else begin
         acc <= next_acc;
         accAddr <= next_accAddr;
         rdata <= next_rdata;
      end
   end

   // latches update at the end of the data phase, so pins move in the
   // cycle after the second cycle of the write
   always_comb begin
      next_octalPortOutputLatch = octalPortOutputLatch;
      next_octalPortSegmentSelect = octalPortSegmentSelect;
      next_triPortOutputLatch = triPortOutputLatch;
      next_quadPortOutputLatch = quadPortOutputLatch;
      next_quadPortOutputType = quadPortOutputType;
      next_modeReg = modeReg;
      if (acc == ACC_WRITE) begin
         // pin-level words take no write: there is nothing to hold
         unique case (decodeReg(accAddr))
            REG_OCT_LATCH: next_octalPortOutputLatch = hwdata[7:0];
            REG_OCT_SEG: next_octalPortSegmentSelect = hwdata[7:0];
            REG_TRI_LATCH: next_triPortOutputLatch = hwdata[2:0];
            REG_QUAD_LATCH: next_quadPortOutputLatch = hwdata[3:0];
            REG_QUAD_TYPE: next_quadPortOutputType = hwdata[3:0];
            REG_MODE: next_modeReg = hwdata[2:0];
            default: next_modeReg = modeReg; // read-only or unmapped
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         octalPortOutputLatch <= RST_OCT_LATCH;
         octalPortSegmentSelect <= RST_OCT_SEG;
         triPortOutputLatch <= RST_TRI_LATCH;
         quadPortOutputLatch <= RST_QUAD_LATCH;
         quadPortOutputType <= RST_QUAD_TYPE;
         modeReg <= RST_MODE;
      end else begin
         octalPortOutputLatch <= next_octalPortOutputLatch;
         octalPortSegmentSelect <= next_octalPortSegmentSelect;
         triPortOutputLatch <= next_triPortOutputLatch;
         quadPortOutputLatch <= next_quadPortOutputLatch;
         quadPortOutputType <= next_quadPortOutputType;
         modeReg <= next_modeReg;
      end
   end

   // falling edge of the stop-release pad, even when we drive it
   always_comb begin
      next_triPin0Last = triPinIn[TRI_STOP_PIN];
      next_edgeFlag = triPin0Last & ~triPinIn[TRI_STOP_PIN];
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         triPin0Last <= 1'b1;
         edgeFlag <= 1'b0;
      end else begin
         triPin0Last <= next_triPin0Last;
         edgeFlag <= next_edgeFlag;
      end
   end

   assign hrdata = rdata;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign extIntEdge = edgeFlag;

   // octal port: segment driver or latch, segment bits push-pull, latch bits open drain
   assign segmentEnable = octalPortSegmentSelect;
   assign octDrive = (octalPortSegmentSelect & segmentDrive)
                   | (~octalPortSegmentSelect & octalPortOutputLatch);
   // a latch one without segment leaves the pad released for input;
   // segment bits use the push-pull style so the driver always owns
   // the pad, port bits only sink
   genvar go;
   generate
      for (go = 0; go < 8; go++) begin : g_oct
         lsp_pin_cell u_cell (
            .outData(octDrive[go]),
            .allowDrive(1'b1),
            .pushPull(octalPortSegmentSelect[go]),
            .padOut(octPinOut[go]),
            .padOe(octPinOe[go])
         );
      end
   endgenerate

   // tri port: sink-only latch drive, oscillator pins and stop float
   assign slowOscEnable = {2{modeReg[MODE_DUAL_BIT]}};
   always_comb begin
      triAllow = {3{modeReg[MODE_GLOBAL_OUTPUT_ENABLE_BIT]}};
      triAllow[TRI_OSC_IN] = triAllow[TRI_OSC_IN]
                             & ~modeReg[MODE_DUAL_BIT];
      triAllow[TRI_OSC_OUT] = triAllow[TRI_OSC_OUT]
                              & ~modeReg[MODE_DUAL_BIT];
      triAllow[TRI_STOP_PIN] = ~modeReg[MODE_STOP_BIT];
   end
   // sink-only cells: a latch one releases the pad, which keeps the
   // interrupt and oscillator functions usable without a direction bit
   genvar gt;
   generate
      for (gt = 0; gt < 3; gt++) begin : g_tri
         lsp_pin_cell u_cell (
            .outData(triPortOutputLatch[gt]),
            .allowDrive(triAllow[gt]),
            .pushPull(1'b0),
            .padOut(triPinOut[gt]),
            .padOe(triPinOe[gt])
         );
      end
   endgenerate

   // quad port: alternate function ANDed in, per-pin drive style
   assign quadData = quadPortOutputLatch
                   & (~quadAltSel | quadAltOut);

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_quad
         lsp_pin_cell u_cell (
            .outData(quadData[gi]),
            .allowDrive(modeReg[MODE_GLOBAL_OUTPUT_ENABLE_BIT]),
            .pushPull(quadPortOutputType[gi]),
            .padOut(quadPinOut[gi]),
            .padOe(quadPinOe[gi])
         );
      end
   endgenerate
endmodule // lsp_parallel_ports
`default_nettype wire

//--- lsp_pkg.sv
`default_nettype none
package lsp_pkg;
   // byte offsets are the printed ones, word-aligned indices times four
   localparam logic [7:0] IDX_OCT_LATCH = 8'h01;
   localparam logic [7:0] IDX_TRI_LATCH = 8'h02;
   localparam logic [7:0] IDX_QUAD_LATCH = 8'h03;
   localparam logic [7:0] IDX_QUAD_TYPE = 8'h04;
   localparam logic [7:0] IDX_OCT_PINS = 8'h08;
   localparam logic [7:0] IDX_TRI_PINS = 8'h09;
   localparam logic [7:0] IDX_QUAD_PINS = 8'h0A;
   localparam logic [7:0] IDX_OCT_SEG = 8'h29;
   localparam logic [7:0] IDX_MODE = 8'h40;
   localparam logic [9:0] ADDR_OCT_LATCH = {IDX_OCT_LATCH, 2'b00};
   localparam logic [9:0] ADDR_TRI_LATCH = {IDX_TRI_LATCH, 2'b00};
   localparam logic [9:0] ADDR_QUAD_LATCH = {IDX_QUAD_LATCH, 2'b00};
   localparam logic [9:0] ADDR_QUAD_TYPE = {IDX_QUAD_TYPE, 2'b00};
   localparam logic [9:0] ADDR_OCT_PINS = {IDX_OCT_PINS, 2'b00};
   localparam logic [9:0] ADDR_TRI_PINS = {IDX_TRI_PINS, 2'b00};
   localparam logic [9:0] ADDR_QUAD_PINS = {IDX_QUAD_PINS, 2'b00};
   localparam logic [9:0] ADDR_OCT_SEG = {IDX_OCT_SEG, 2'b00};
   localparam logic [9:0] ADDR_MODE = {IDX_MODE, 2'b00};
   // mode register fields
   localparam int MODE_DUAL_BIT = 0;
   localparam int MODE_GLOBAL_OUTPUT_ENABLE_BIT = 1;
   localparam int MODE_STOP_BIT = 2;
   // reset values
   localparam logic [7:0] RST_OCT_LATCH = 8'hFF;
   localparam logic [7:0] RST_OCT_SEG = 8'h00;
   localparam logic [2:0] RST_TRI_LATCH = 3'h7;
   localparam logic [3:0] RST_QUAD_LATCH = 4'hF;
   localparam logic [3:0] RST_QUAD_TYPE = 4'h0;
   localparam logic [2:0] RST_MODE = 3'h2;
   // pin roles inside the tri port
   localparam int TRI_STOP_PIN = 0;
   localparam int TRI_OSC_IN = 1;
   localparam int TRI_OSC_OUT = 2;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   typedef enum logic [1:0] {
      ACC_IDLE,
      ACC_READ,
      ACC_WRITE
   } lsp_acc_t;
endpackage
`default_nettype wire

//--- lsp_pin_cell.sv
`default_nettype none
// one pad cell: drives the pad from a data value with a selectable style
module lsp_pin_cell (
   input wire logic outData,
   input wire logic allowDrive,
   input wire logic pushPull,
   output logic padOut,
   output logic padOe
);
   // open drain only sinks: a one leaves the pad free for input use
   always_comb begin
      padOut = outData;
      padOe = allowDrive & (pushPull | ~outData);
   end
endmodule // lsp_pin_cell
`default_nettype wire

//--- lsp_pad_model.sv
`default_nettype none
module lsp_pad_model #(parameter int W = 8) (
   input wire logic [W-1:0] pinOut, pinOe, extLevel,
   output logic [W-1:0] pinLevel
);
   // outside always drives, so a released pad never floats
   assign pinLevel = (pinOe & pinOut) | (~pinOe & extLevel);
endmodule // lsp_pad_model
`default_nettype wire

//--- lsp_parallel_ports_properties.sv
`default_nettype none
module lsp_parallel_ports_properties
   import lsp_pkg::*;
(
   input wire logic clk, rstn, hsel, hwrite, hready, extIntEdge,
   input wire logic [31:0] haddr, hwdata, hrdata,
   input wire logic [1:0] htrans, slowOscEnable,
   input wire logic [7:0] octPinIn, octPinOe, segmentEnable,
   input wire logic [2:0] triPinIn, triPinOe
);
   logic tk, rQ, wQ;
   logic [9:0] aQ;
   logic [7:0] lat;
   logic [2:0] md;
   // shadow of latch and mode, written in the data phase
   assign tk = hsel & hready & (htrans == HTRANS_NONSEQ);
   always_ff @(posedge clk) begin
      if (!rstn) begin
         rQ <= 1'b0;
         wQ <= 1'b0;
         lat <= RST_OCT_LATCH;
         md <= RST_MODE;
      end else begin
         rQ <= tk & !hwrite;
         wQ <= tk & hwrite;
         aQ <= haddr[9:0];
         if (wQ && aQ == ADDR_OCT_LATCH) lat <= hwdata[7:0];
         if (wQ && aQ == ADDR_MODE) md <= hwdata[2:0];
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   property p_oct;
      md[MODE_GLOBAL_OUTPUT_ENABLE_BIT] |-> octPinOe == (segmentEnable | ~lat); endproperty
   a_oct: assert property (p_oct) else $error("octal drive off");
   property p_stop; md[MODE_STOP_BIT] |-> !triPinOe[0]; endproperty
   a_stop: assert property (p_stop) else $error("stop pin driven");
   property p_osc; slowOscEnable == {2{md[MODE_DUAL_BIT]}}; endproperty
   a_osc: assert property (p_osc) else $error("oscillator pins off");
   property p_int; $fell(triPinIn[0]) |=> extIntEdge; endproperty
   a_int: assert property (p_int) else $error("edge flag missing");
   property p_int_one; extIntEdge |=> !extIntEdge; endproperty
   a_int_one: assert property (p_int_one) else $error("flag too long");
   property p_lat; rQ && aQ == ADDR_OCT_LATCH |-> hrdata == {24'h0, lat};
   endproperty
   a_lat: assert property (p_lat) else $error("latch read off");
   property p_opin;
      rQ && aQ == ADDR_OCT_PINS |-> hrdata == {24'h0, $past(octPinIn)};
   endproperty
   a_opin: assert property (p_opin) else $error("octal pins off");
   property p_tpin;
      rQ && aQ == ADDR_TRI_PINS |-> hrdata == {29'h0, $past(triPinIn)};
   endproperty
   a_tpin: assert property (p_tpin) else $error("tri pins off");
endmodule // lsp_parallel_ports_properties
bind lsp_parallel_ports lsp_parallel_ports_properties i_chk (.*);
`default_nettype wire

//--- test_lcd_shared_parallel_ports.sv
`default_nettype none
module test_lcd_shared_parallel_ports;
   timeunit 1ns;
   timeprecision 100ps;
   import lsp_pkg::*;
   logic clk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [1:0] htrans = 2'h0, slowOscEnable;
   logic [2:0] hsize = HSIZE_WORD;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic hreadyout, hresp, extIntEdge;
   logic [7:0] octPinIn, octPinOut, octPinOe, segmentEnable;
   logic [7:0] segmentDrive = 8'h00, octExt = 8'hFF;
   logic [2:0] triPinIn, triPinOut, triPinOe, triExt = 3'h7;
   logic [3:0] quadPinIn, quadPinOut, quadPinOe, quadExt = 4'hF;
   logic [3:0] quadAltOut = 4'h0, quadAltSel = 4'h0;
   logic [9:0] regAddr[5] = '{ADDR_OCT_LATCH, ADDR_TRI_LATCH,
      ADDR_QUAD_LATCH, ADDR_QUAD_TYPE, ADDR_OCT_SEG};
   logic [7:0] regReset[5] = '{8'hFF, 8'h07, 8'h0F, 8'h00, 8'h00};
   int regWidth[5] = '{8, 3, 4, 4, 8};
   int n_fail = 0, comparisons = 0, cyc = 0;
   lsp_parallel_ports i_lsp_parallel_ports (.hready(hreadyout), .*);
   lsp_pad_model #(.W(8)) i_lsp_pad_model_oct (.pinOut(octPinOut),
      .pinOe(octPinOe), .extLevel(octExt), .pinLevel(octPinIn));
   lsp_pad_model #(.W(3)) i_lsp_pad_model_tri (.pinOut(triPinOut),
      .pinOe(triPinOe), .extLevel(triExt), .pinLevel(triPinIn));
   lsp_pad_model #(.W(4)) i_lsp_pad_model_quad (.pinOut(quadPinOut),
      .pinOe(quadPinOe), .extLevel(quadExt), .pinLevel(quadPinIn));
   // 250 MHz
   always #2 clk = ~clk;
   // the whole run needs far fewer cycles than this ceiling
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_fail++;
         tally_and_finish();
      end
   end
   task automatic chk(input string nm, input logic [31:0] e, g);
      comparisons++;
      if (g !== e) begin
         n_fail++;
         $display("[FAIL] %s exp %h got %h", nm, e, g);
      end
   endtask
   // undefined upper bits of a narrow port read as zero
   function automatic logic [31:0] fieldWord(input logic [7:0] v, int w);
      return {24'h0, v} & ((32'h1 << w) - 32'h1);
   endfunction
   // one word transfer; a read is compared with d
   task automatic xfer(input logic w, input logic [9:0] a, logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      haddr <= {22'h0, a};
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      chk("hresp", 32'h0, {31'h0, hresp});
      if (!w) chk($sformatf("read %h", a), d, hrdata);
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      logic [31:0] v;
      int n;
      void'($urandom(13334));
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      // reset value, random write and read back, then input use again
      for (int i = 0; i < 5; i++) begin
         xfer(1'b0, regAddr[i], {24'h0, regReset[i]});
         v = $urandom;
         xfer(1'b1, regAddr[i], v);
         xfer(1'b0, regAddr[i], fieldWord(v[7:0], regWidth[i]));
         xfer(1'b1, regAddr[i], {24'h0, regReset[i]});
      end
      // random outside levels come back raw
      repeat (12) begin
         v = $urandom;
         octExt <= v[7:0];
         triExt <= v[10:8];
         quadExt <= v[14:11];
         quadAltOut <= v[18:15];
         segmentDrive <= v[26:19];
         xfer(1'b0, ADDR_OCT_PINS, fieldWord(v[7:0], 8));
         xfer(1'b0, ADDR_TRI_PINS, fieldWord(8'(v[10:8]), 3));
         xfer(1'b0, ADDR_QUAD_PINS, fieldWord(8'(v[14:11]), 4));
      end
      // pin places ignore writes; unmapped reads zero
      triExt <= 3'h7;
      xfer(1'b1, ADDR_OCT_PINS, 32'h0);
      xfer(1'b0, ADDR_OCT_LATCH, 32'hFF);
      xfer(1'b0, 10'h3FC, 32'h0);
      // segment bits follow the driver, the others their latch bit
      xfer(1'b1, ADDR_OCT_LATCH, 32'h3C);
      xfer(1'b1, ADDR_OCT_SEG, 32'hF0);
      repeat (4) begin
         v = $urandom;
         @(posedge clk);
         segmentDrive <= v[7:0];
         @(negedge clk);
         chk("octPinOut", {24'h0, v[7:4], 4'hC}, {24'h0, octPinOut});
      end
      chk("segmentEnable", 32'hF0, {24'h0, segmentEnable});
      chk("octPinOe", 32'hF3, {24'h0, octPinOe});
      xfer(1'b1, ADDR_OCT_SEG, 32'h0);
      xfer(1'b1, ADDR_OCT_LATCH, 32'hFF);
      // timer output on the two low quad pins, latch left at one
      xfer(1'b1, ADDR_QUAD_LATCH, 32'hF);
      xfer(1'b1, ADDR_QUAD_TYPE, 32'hF);
      repeat (4) begin
         v = $urandom;
         @(posedge clk);
         quadAltSel <= 4'h3;
         quadAltOut <= v[3:0];
         @(negedge clk);
         chk("quadPinOut", {30'h3, v[1:0]}, {28'h0, quadPinOut});
      end
      @(posedge clk);
      quadAltSel <= 4'h0;
      // push-pull drives all bits, open drain only the zeros
      xfer(1'b1, ADDR_QUAD_LATCH, 32'h5);
      for (int t = 1; t >= 0; t--) begin
         xfer(1'b1, ADDR_QUAD_TYPE, t ? 32'hF : 32'h0);
         @(negedge clk);
         chk("quadPinOe", t ? 32'hF : 32'hA, {28'h0, quadPinOe});
      end
      // own low drive on the first tri pin still flags one edge
      xfer(1'b1, ADDR_TRI_LATCH, 32'h6);
      n = 0;
      repeat (4) begin
         @(negedge clk);
         n += int'(extIntEdge === 1'b1);
      end
      chk("extIntEdge", 32'h1, n);
      xfer(1'b1, ADDR_MODE, 32'h6);
      @(negedge clk);
      chk("stop pin oe", 32'h0, {31'h0, triPinOe[0]});
      for (int m = 1; m >= 0; m--) begin
         xfer(1'b1, ADDR_MODE, m ? 32'h3 : 32'h2);
         @(negedge clk);
         chk("slowOsc", m ? 32'h3 : 32'h0, {30'h0, slowOscEnable});
      end
      tally_and_finish();
   end
endmodule // test_lcd_shared_parallel_ports
`default_nettype wire
